// ### hdl/dpra_lane_bit.sv
// One DQ lane: picks the pattern bit for a beat in the selected readout format
`timescale 1ns/1ps
`default_nettype none

module dpra_lane_bit #(
    parameter int LANE = 0
) (
    input  wire logic [dpra_pkg::LOCS*dpra_pkg::PAT_W-1:0] pats,
    input  wire logic [1:0]                                fmt,
    input  wire logic [1:0]                                loc,
    input  wire logic [2:0]                                beat,
    output logic                                           bit_o
);
    import dpra_pkg::*;

    localparam logic [1:0] NIB_OFS  = 2'(LANE % 4);
    localparam logic [2:0] BYTE_OFS = 3'(LANE % 8);

    logic [1:0] stag_loc;

    // Offset wraps over four locations; upper lanes reuse lower offsets
    assign stag_loc = loc + NIB_OFS;

    // Reserved code yields zero; it is never scheduled
    always_comb begin
        unique case (fmt)
            FMT_SERIAL:   bit_o = pats[{loc, beat}];
            FMT_PARALLEL: bit_o = pats[{2'b00, BYTE_OFS}];
            FMT_STAGGER:  bit_o = pats[{stag_loc, beat}];
            FMT_RSVD:     bit_o = 1'b0;
        endcase
    end

endmodule : dpra_lane_bit

`default_nettype wire

// ### hdl/dpra_pattern_regs.sv
// Pattern register logic: APB mode registers, command decode, read scheduling, DQ drive
// How it works
// - Staggered read to location k drives lane i from location (k+i) mod 4.
// - Upper nibble repeats lower nibble in serial and staggered formats; on x16 the upper byte copies the lower.
// - Back-to-back pattern reads give contiguous bursts, no idle beats between.
// - Chopped reads return beats 0..3, or 4..7 with A2 high; last four beats are not driven.
// - Parity delay is added to read latency when parity mode is enabled.
// - Pattern write stores A[7:0] into the page-0 location, bit per beat.
// - Written patterns are kept until reset re-initialises the block.
// - BA1:BA0 pick location 0..3 on writes; A10, BG1, BG0 ignored.
// - In pattern mode page-0 reads and writes go to the pattern locations; other pages read as zero and refuse writes.
// - Format field: 00 serial, 01 parallel, 10 staggered, 11 reserved.
// - Read data starts read latency (additive plus CAS) after the command.
`timescale 1ns/1ps
`default_nettype none

module dpra_pattern_regs #(
    parameter int RL_DEPTH = 128
) (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire dpra_pkg::dpra_apb_req_t apb_req,
    output var  dpra_pkg::dpra_apb_rsp_t apb_rsp,
    input  wire dpra_pkg::dpra_cmd_t     cmd,
    output logic [dpra_pkg::DQ_W-1:0]    dq,
    output logic [dpra_pkg::DQ_W-1:0]    dq_oe
);
    import dpra_pkg::*;

    typedef enum logic {BS_IDLE, BS_BURST} dpra_bstate_t;

    // ********************************
    // Declarations
    // ********************************
    logic                         mode_en_q,  mode_en_d;
    logic [1:0]                   page_q,     page_d;
    logic [1:0]                   fmt_q,      fmt_d;
    logic [1:0]                   blf_q,      blf_d;
    logic [LAT_W-1:0]             al_q,       al_d;
    logic [LAT_W-1:0]             cl_q,       cl_d;
    logic [LAT_W-1:0]             pl_q,       pl_d;
    logic                         pen_q,      pen_d;
    logic                         x16_q,      x16_d;
    logic [STS_W-1:0]             sts_q,      sts_d;
    logic [STS_W-1:0]             sts_set;
    dpra_apb_rsp_t                rsp_q,      rsp_d;
    logic [LOCS-1:0][PAT_W-1:0]   pat_q,      pat_d;
    dpra_slot_t                   slot_q [RL_DEPTH];
    dpra_slot_t                   slot_d [RL_DEPTH];
    dpra_slot_t                   slot_new;
    dpra_slot_t                   tap;
    dpra_bstate_t                 bst_q,      bst_d;
    logic [2:0]                   cnt_q,      cnt_d;
    logic [1:0]                   loc_q,      loc_d;
    logic                         chop_q,     chop_d;
    logic                         upper_q,    upper_d;
    logic                         blank_q,    blank_d;
    logic [DQ_W-1:0]              dq_q,       dq_d;
    logic [DQ_W-1:0]              oe_q,       oe_d;
    logic [DQ_W-1:0]              lane_bits;
    logic [2:0]                   beat_d;
    logic [7:0]                   rl;
    int                           tap_idx;
    logic                         apb_setup;
    logic                         apb_done;

    // ********************************
    // APB slave and mode registers
    // ********************************

    // Zero wait states: pready in the first access cycle
    assign apb_setup = apb_req.psel & ~apb_req.penable;
    assign apb_done  = apb_req.psel & apb_req.penable & rsp_q.pready;

    // Read data is set up in setup; writes land only at the completing edge
    always_comb begin
        mode_en_d = mode_en_q;
        page_d    = page_q;
        fmt_d     = fmt_q;
        blf_d     = blf_q;
        al_d      = al_q;
        cl_d      = cl_q;
        pl_d      = pl_q;
        pen_d     = pen_q;
        x16_d     = x16_q;
        rsp_d     = '0;
        if (apb_setup) begin
            rsp_d.pready = 1'b1;
            unique case (apb_req.paddr)
                OFS_MODE3: begin
                    rsp_d.prdata[MODE3_EN_BIT] = mode_en_q;
                    rsp_d.prdata[MODE3_PAGE_LSB +: 2] = page_q;
                    rsp_d.prdata[MODE3_FMT_LSB +: 2] = fmt_q;
                end
                OFS_BURST: rsp_d.prdata[BURST_LSB +: 2] = blf_q;
                OFS_LAT: begin
                    rsp_d.prdata[LAT_AL_LSB +: LAT_W] = al_q;
                    rsp_d.prdata[LAT_CL_LSB +: LAT_W] = cl_q;
                    rsp_d.prdata[LAT_PL_LSB +: LAT_W] = pl_q;
                    rsp_d.prdata[LAT_PEN_BIT] = pen_q;
                    rsp_d.prdata[LAT_X16_BIT] = x16_q;
                end
                OFS_STS: begin
                    rsp_d.prdata[STS_W-1:0] = sts_q;
                    rsp_d.prdata[STS_BUSY_BIT] = (bst_q == BS_BURST);
                end
                OFS_PAT: rsp_d.prdata = pat_q;
                default: rsp_d.pslverr = 1'b1;
            endcase
        end
        if (apb_done && apb_req.pwrite) begin
            unique case (apb_req.paddr)
                OFS_MODE3: begin
                    mode_en_d = apb_req.pwdata[MODE3_EN_BIT];
                    page_d    = apb_req.pwdata[MODE3_PAGE_LSB +: 2];
                    fmt_d     = apb_req.pwdata[MODE3_FMT_LSB +: 2];
                end
                OFS_BURST: blf_d = apb_req.pwdata[BURST_LSB +: 2];
                OFS_LAT: begin
                    al_d  = apb_req.pwdata[LAT_AL_LSB +: LAT_W];
                    cl_d  = apb_req.pwdata[LAT_CL_LSB +: LAT_W];
                    pl_d  = apb_req.pwdata[LAT_PL_LSB +: LAT_W];
                    pen_d = apb_req.pwdata[LAT_PEN_BIT];
                    x16_d = apb_req.pwdata[LAT_X16_BIT];
                end
                default: ;
            endcase
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always_comb begin
        sts_d = sts_q | sts_set;
        if (apb_done && apb_req.pwrite && apb_req.paddr == OFS_STS) begin
            sts_d = (sts_q & ~apb_req.pwdata[STS_W-1:0]) | sts_set;
        end
    end

    // Register stage for the bus side
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_en_q <= MODE_EN_RST;
            page_q    <= PAGE_RST;
            fmt_q     <= FMT_RST;
            blf_q     <= BURST_RST;
            al_q      <= AL_RST;
            cl_q      <= CL_RST;
            pl_q      <= PL_RST;
            pen_q     <= PEN_RST;
            x16_q     <= X16_RST;
            sts_q     <= '0;
            rsp_q     <= '0;
        end else begin
            mode_en_q <= mode_en_d;
            page_q    <= page_d;
            fmt_q     <= fmt_d;
            blf_q     <= blf_d;
            al_q      <= al_d;
            cl_q      <= cl_d;
            pl_q      <= pl_d;
            pen_q     <= pen_d;
            x16_q     <= x16_d;
            sts_q     <= sts_d;
            rsp_q     <= rsp_d;
        end
    end

    // ********************************
    // Command decode, pattern store and read scheduling
    // ********************************

    // Commands come from mclk logic, so no synchroniser
    always_comb begin
        pat_d    = pat_q;
        sts_set  = '0;
        slot_new = '0;
        if (mode_en_q) begin
            unique case (cmd.kind)
                CMD_RD, CMD_RDA: begin
                    // BG and A10 play no part; BA is the start location
                    slot_new.loc   = cmd.ba;
                    slot_new.blank = (page_q != PAGE_ZERO);
                    unique case (blf_q)
                        BL_FIXED4: slot_new.chop = 1'b1;
                        BL_OTF: begin
                            // On-the-fly chop is unsupported; a low A12 still reads BL8
                            slot_new.chop        = 1'b0;
                            sts_set[STS_A12]     = ~cmd.addr[12];
                        end
                        default:   slot_new.chop = 1'b0;
                    endcase
                    slot_new.upper = slot_new.chop & cmd.addr[2];
                    if (cmd.addr[1:0] != 2'b00 || (cmd.addr[2] && !slot_new.chop)) begin
                        sts_set[STS_ADDR] = 1'b1;
                    end
                    if (fmt_q == FMT_PARALLEL && cmd.ba != 2'b00) begin
                        sts_set[STS_ADDR] = 1'b1;
                    end
                    // Reserved format is flagged and the read is dropped
                    sts_set[STS_FMT] = (fmt_q == FMT_RSVD);
                    slot_new.valid   = (fmt_q != FMT_RSVD);
                end
                CMD_WR, CMD_WRA: begin
                    if (page_q == PAGE_ZERO) begin
                        pat_d[cmd.ba] = cmd.addr[PAT_W-1:0];
                    end else begin
                        sts_set[STS_PAGE] = 1'b1;
                    end
                end
                CMD_REF_FGR: sts_set[STS_FGR] = 1'b1;
                default: ;
            endcase
        end
    end

    // Latency line: slot j holds the read taken j+1 edges ago
    always_comb begin
        slot_d[0] = slot_new;
        for (int j = 1; j < RL_DEPTH; j++) begin
            slot_d[j] = slot_q[j-1];
        end
    end

    // Patterns survive all but reset, the re-initialisation
    always_ff @(posedge mclk) begin
        if (rst) begin
            pat_q <= {LOCS{PAT_RST}};
            for (int j = 0; j < RL_DEPTH; j++) begin
                slot_q[j] <= '0;
            end
        end else begin
            pat_q <= pat_d;
            for (int j = 0; j < RL_DEPTH; j++) begin
                slot_q[j] <= slot_d[j];
            end
        end
    end

    // ********************************
    // Burst engine and DQ drive
    // ********************************

    // Latency is capped by the line depth; a zero setting behaves as one cycle
    assign rl      = 8'(al_q) + 8'(cl_q) + (pen_q ? 8'(pl_q) : 8'h00);
    assign tap_idx = (rl == 8'h00) ? 0 : ((int'(rl) > RL_DEPTH) ? RL_DEPTH - 1 : int'(rl) - 1);
    assign tap     = slot_q[tap_idx];

    // A burst due on the last beat of the previous one follows seamlessly
    always_comb begin
        bst_d   = bst_q;
        cnt_d   = cnt_q;
        loc_d   = loc_q;
        chop_d  = chop_q;
        upper_d = upper_q;
        blank_d = blank_q;
        if (tap.valid) begin
            bst_d   = BS_BURST;
            cnt_d   = 3'h0;
            loc_d   = tap.loc;
            chop_d  = tap.chop;
            upper_d = tap.upper;
            blank_d = tap.blank;
        end else begin
            unique case (bst_q)
                BS_IDLE: ;
                BS_BURST: begin
                    if (cnt_q == LAST_BEAT) begin
                        bst_d = BS_IDLE;
                    end else begin
                        cnt_d = cnt_q + 3'h1;
                    end
                end
            endcase
        end
    end

    // Chopped bursts with A2 high start at beat four
    assign beat_d = {upper_d, 2'b00} + cnt_d;

    // One lane selector per DQ bit
    for (genvar i = 0; i < DQ_W; i++) begin : g_lane
        dpra_lane_bit #(
            .LANE (i)
        ) u_lane (
            .pats  (pat_q),
            .fmt   (fmt_q),
            .loc   (loc_d),
            .beat  (beat_d),
            .bit_o (lane_bits[i])
        );
    end

    // Upper byte drives only on x16; chopped tail beats are released
    always_comb begin
        for (int i = 0; i < DQ_W; i++) begin
            oe_d[i] = (bst_d == BS_BURST) && (!chop_d || cnt_d < CHOP_BEATS)
                      && (i < PAT_W || x16_q);
            dq_d[i] = oe_d[i] && !blank_d && lane_bits[i];
        end
    end

    // Register stage for the burst side
    always_ff @(posedge mclk) begin
        if (rst) begin
            bst_q   <= BS_IDLE;
            cnt_q   <= 3'h0;
            loc_q   <= 2'b00;
            chop_q  <= 1'b0;
            upper_q <= 1'b0;
            blank_q <= 1'b0;
            dq_q    <= '0;
            oe_q    <= '0;
        end else begin
            bst_q   <= bst_d;
            cnt_q   <= cnt_d;
            loc_q   <= loc_d;
            chop_q  <= chop_d;
            upper_q <= upper_d;
            blank_q <= blank_d;
            dq_q    <= dq_d;
            oe_q    <= oe_d;
        end
    end

    assign apb_rsp = rsp_q;
    assign dq      = dq_q;
    assign dq_oe   = oe_q;

endmodule : dpra_pattern_regs

`default_nettype wire

// ### shared/dpra_pkg.sv
// Shared constants, register map and carrier types of the pattern register block
`default_nettype none

package dpra_pkg;

    // ********************************
    // Register offsets (byte addresses on APB)
    // ********************************
    localparam logic [11:0] OFS_MODE3 = 12'h000;  // third_mode_register
    localparam logic [11:0] OFS_BURST = 12'h004;  // burst_mode_register
    localparam logic [11:0] OFS_LAT   = 12'h008;  // latency settings
    localparam logic [11:0] OFS_STS   = 12'h00C;  // sticky status, write one to clear
    localparam logic [11:0] OFS_PAT   = 12'h010;  // pattern readback, read only

    // ********************************
    // Field positions
    // ********************************
    localparam int MODE3_PAGE_LSB = 0;
    localparam int MODE3_EN_BIT   = 2;
    localparam int MODE3_FMT_LSB  = 11;
    localparam int BURST_LSB      = 0;
    localparam int LAT_W          = 6;
    localparam int LAT_AL_LSB     = 0;
    localparam int LAT_CL_LSB     = 8;
    localparam int LAT_PL_LSB     = 16;
    localparam int LAT_PEN_BIT    = 24;
    localparam int LAT_X16_BIT    = 28;
    localparam int STS_W          = 5;
    localparam int STS_ADDR       = 0;
    localparam int STS_FGR        = 1;
    localparam int STS_PAGE       = 2;
    localparam int STS_A12        = 3;
    localparam int STS_FMT        = 4;
    localparam int STS_BUSY_BIT   = 8;

    // ********************************
    // Reset values
    // ********************************
    localparam logic             MODE_EN_RST = 1'b0;
    localparam logic [1:0]       PAGE_RST    = 2'b00;
    localparam logic [1:0]       FMT_RST     = 2'b00;
    localparam logic [1:0]       BURST_RST   = 2'b00;
    localparam logic [LAT_W-1:0] AL_RST      = 6'h00;
    localparam logic [LAT_W-1:0] CL_RST      = 6'h0A;
    localparam logic [LAT_W-1:0] PL_RST      = 6'h00;
    localparam logic             PEN_RST     = 1'b0;
    localparam logic             X16_RST     = 1'b1;
    localparam logic [7:0]       PAT_RST     = 8'h00;

    // ********************************
    // Encodings and burst shape
    // ********************************
    localparam logic [1:0] FMT_SERIAL   = 2'b00;
    localparam logic [1:0] FMT_PARALLEL = 2'b01;
    localparam logic [1:0] FMT_STAGGER  = 2'b10;
    localparam logic [1:0] FMT_RSVD     = 2'b11;
    localparam logic [1:0] BL_FIXED8    = 2'b00;
    localparam logic [1:0] BL_OTF       = 2'b01;
    localparam logic [1:0] BL_FIXED4    = 2'b10;
    localparam logic [1:0] PAGE_ZERO    = 2'b00;
    localparam int         PAT_W        = 8;
    localparam int         LOCS         = 4;
    localparam int         DQ_W         = 16;
    localparam logic [2:0] LAST_BEAT    = 3'h7;
    localparam logic [2:0] CHOP_BEATS   = 3'h4;

    // ********************************
    // Carrier types
    // ********************************
    typedef enum logic [2:0] {
        CMD_NOP, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA, CMD_REF, CMD_REF_FGR
    } dpra_cmd_kind_t;

    typedef struct packed {
        dpra_cmd_kind_t kind;
        logic [1:0]     bg;
        logic [1:0]     ba;
        logic [13:0]    addr;
    } dpra_cmd_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dpra_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } dpra_apb_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] loc;
        logic       chop;
        logic       upper;
        logic       blank;
    } dpra_slot_t;

endpackage : dpra_pkg

`default_nettype wire

// ### testbench/dpra_ctrl_model.sv
// Memory controller model that issues pattern-mode commands
`timescale 1ns/1ps
`default_nettype none
module dpra_ctrl_model (
    input  wire logic                mclk,
    output var  dpra_pkg::dpra_cmd_t cmd
);
    import dpra_pkg::*;
    initial cmd = '0;
    // One command per call; gap sets the pace
    task automatic op(input dpra_cmd_kind_t k, input logic [1:0] ba, input logic [13:0] a,
                      input int gap);
        dpra_cmd_t c;
        c.kind = k; // Only 1x refresh unless a refusal is wanted
        c.ba   = ba; // Location select
        c.bg   = ~ba; // Group bits are don't-care
        c.addr = a | 14'h0400; // A10 is don't-care; write data in A[7:0] kept whole
        if (k == CMD_RD || k == CMD_RDA) c.addr[1:0] = 2'b00; // Nibble start
        @(posedge mclk);
        cmd <= c; // Pattern byte sent raw, never inverted
        @(posedge mclk);
        // Released bus shows inverted lines, never the last value
        cmd <= {CMD_NOP, ~c[17:0]};
        repeat (gap - 2) @(posedge mclk); // Recovery wait
    endtask : op
endmodule : dpra_ctrl_model
`default_nettype wire

// ### testbench/dpra_pattern_regs_assertions.sv
// Port-level checker for the pattern register block
`timescale 1ns/1ps
`default_nettype none
module dpra_chk (
    input wire logic                      mclk,
    input wire logic                      rst,
    input wire dpra_pkg::dpra_apb_req_t   apb_req,
    input wire dpra_pkg::dpra_apb_rsp_t   apb_rsp,
    input wire dpra_pkg::dpra_cmd_t       cmd,
    input wire logic [dpra_pkg::DQ_W-1:0] dq,
    input wire logic [dpra_pkg::DQ_W-1:0] dq_oe
);
    import dpra_pkg::*;
    logic [31:0] lat_q, lat_d;
    logic [8:0]  since_q, since_d;
    logic [8:0]  rl;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Shadow latency and age of last read; saturates, never wraps
    always_comb begin
        lat_d = lat_q;
        if (apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
            && apb_req.paddr == OFS_LAT) lat_d = apb_req.pwdata;
        since_d = (since_q == 9'h1FF) ? since_q : since_q + 9'h001;
        if (cmd.kind == CMD_RD || cmd.kind == CMD_RDA) since_d = 9'h000;
        rl = 9'(lat_q[LAT_AL_LSB+:LAT_W]) + 9'(lat_q[LAT_CL_LSB+:LAT_W])
           + (lat_q[LAT_PEN_BIT] ? 9'(lat_q[LAT_PL_LSB+:LAT_W]) : 9'h000);
    end
    // Register the shadows
    always_ff @(posedge mclk) begin
        if (rst) begin
            lat_q   <= 32'(CL_RST) << LAT_CL_LSB;
            since_q <= 9'h1FF;
        end else begin
            lat_q   <= lat_d;
            since_q <= since_d;
        end
    end
    a_apb_zero_wait: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no pready after setup");
    a_unmapped_err: assert property (apb_req.psel && !apb_req.penable && apb_req.paddr[1:0] == 2'b00
        |=> apb_rsp.pslverr == ($past(apb_req.paddr) > OFS_PAT)) else $error("pslverr wrong");
    a_upper_copy: assert property (dq_oe[8] |-> dq[15:8] == dq[7:0])
        else $error("upper byte differs");
    a_byte_oe: assert property (dq_oe[7:0] inside {8'h00, 8'hFF})
        else $error("lower byte enables split");
    a_undriven_zero: assert property ((dq & ~dq_oe) == 16'h0000)
        else $error("undriven lane not zero");
    a_burst_min: assert property ($rose(dq_oe[0]) |-> dq_oe[0] [*4])
        else $error("burst shorter than four beats");
    a_read_latency: assert property ($rose(dq_oe[0]) |-> since_q == rl)
        else $error("read data at wrong latency");
    a_idle_quiet: assert property (since_q >= rl + 9'h008 |-> dq_oe == 16'h0000)
        else $error("lanes driven with no read");
    c_read: cover property ($rose(dq_oe[0]));
    c_err: cover property (apb_rsp.pslverr);
    c_chop: cover property (dq_oe[0] [*4] ##1 !dq_oe[0]);
endmodule : dpra_chk
bind dpra_pattern_regs dpra_chk u_chk (.mclk(mclk), .rst(rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .cmd(cmd), .dq(dq), .dq_oe(dq_oe));
`default_nettype wire

// ### testbench/tb_dram_pattern_register_access.sv
// Self-checking testbench for the pattern register block
`timescale 1ns/1ps
`default_nettype none
module tb_dram_pattern_register_access;
    import dpra_pkg::*;
    logic            mclk = 1'b0;
    logic            rst = 1'b1;
    dpra_apb_req_t   apb_req = '0;
    dpra_apb_rsp_t   apb_rsp;
    dpra_cmd_t       cmd;
    logic [DQ_W-1:0] dq;
    logic [DQ_W-1:0] dq_oe;
    logic [7:0]      pat [4] = '{8'hA5, 8'h3C, 8'h0F, 8'hC1};
    int              error_cnt = 0;
    int              samples_checked = 0;
    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    // Short latency pipe keeps the run quick
    dpra_pattern_regs #(.RL_DEPTH(16)) uut (.mclk(mclk), .rst(rst), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .cmd(cmd), .dq(dq), .dq_oe(dq_oe));
    dpra_ctrl_model ctl (.mclk(mclk), .cmd(cmd));
    // Counts, verdict, stop
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk
    // APB master: request held until pready at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [32:0] r);
        int n = 0;
        @(posedge mclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        r = {apb_rsp.pslverr, apb_rsp.prdata};
        apb_req <= '0;
        if (apb_rsp.pready !== 1'b1) begin
            chk(33'h0, 33'h1);
            give_verdict();
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic err);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, {err, exp});
    endtask : rchk
    function automatic logic [31:0] lat(input int al, cl, pl, input logic pen, x16);
        return (32'(al) << LAT_AL_LSB) | (32'(cl) << LAT_CL_LSB) | (32'(pl) << LAT_PL_LSB)
             | (32'(pen) << LAT_PEN_BIT) | (32'(x16) << LAT_X16_BIT);
    endfunction : lat
    function automatic logic [31:0] md(input logic [1:0] f, p);
        return (32'(f) << MODE3_FMT_LSB) | (32'h1 << MODE3_EN_BIT) | 32'(p);
    endfunction : md
    // Expected enables and data of one beat
    function automatic logic [31:0] beat(input logic [1:0] f, ba, input int b, input logic x16);
        logic [15:0] d;
        logic [15:0] o;
        for (int i = 0; i < 16; i++) begin
            o[i] = x16 || i < 8;
            d[i] = o[i] & (f == FMT_PARALLEL ? pat[0][i % 8] :
                   f == FMT_STAGGER ? pat[(ba + i % 4) % 4][b] : pat[ba][b]);
        end
        return {o, d};
    endfunction : beat
    // Check n beats and the quiet beat after
    task automatic collect(input logic [1:0] f, ba, input int n, input logic x16,
                           input int base, input logic chop);
        int w = 0;
        do begin
            @(negedge mclk);
            w++;
        end while (dq_oe === 16'h0000 && w < 40);
        if (dq_oe === 16'h0000) begin
            chk(33'h0, 33'h1);
            give_verdict();
        end
        for (int c = 0; c <= n; c++) begin
            chk({dq_oe, dq}, (c == n || (chop && c >= 4)) ? 32'h0
                : beat(f, ba + 2'(c / 8), base + c % 8, x16));
            @(negedge mclk);
        end
    endtask : collect
    task automatic rd_burst(input logic [1:0] f, ba, input logic [13:0] a, input logic x16,
                            input int base, input logic chop);
        fork
            ctl.op(CMD_RD, ba, a, 8);
            collect(f, ba, 8, x16, base, chop);
        join
    endtask : rd_burst
    // Reset values, refused accesses, commands outside pattern mode
    task automatic t_reset_map;
        rchk(OFS_MODE3, 32'h0, 1'b0);
        rchk(OFS_LAT, lat(AL_RST, CL_RST, PL_RST, PEN_RST, X16_RST), 1'b0);
        rchk(OFS_STS, 32'h0, 1'b0);
        wr(OFS_PAT, 32'hFFFF_FFFF);
        rchk(OFS_PAT, 32'h0, 1'b0);
        rchk(12'h020, 32'h0, 1'b1);
        ctl.op(CMD_WR, 2'b01, 14'h00FF, 4);
        ctl.op(CMD_RD, 2'b01, 14'h0000, 20);
        rchk(OFS_PAT, 32'h0, 1'b0);
    endtask : t_reset_map
    // Pattern writes to every location
    task automatic t_write;
        wr(OFS_MODE3, md(FMT_STAGGER, PAGE_ZERO));
        for (int k = 0; k < 4; k++) ctl.op(k % 2 ? CMD_WRA : CMD_WR, 2'(k), {6'h2A, pat[k]}, 4);
        rchk(OFS_PAT, {pat[3], pat[2], pat[1], pat[0]}, 1'b0);
    endtask : t_write
    // Serial, parallel and staggered formats, both widths, then back-to-back reads
    task automatic t_reads;
        for (int f = 0; f < 3; f++) begin
            for (int x = 0; x < 2; x++) begin
                wr(OFS_LAT, lat(0, 3, 0, 1'b0, x[0]));
                wr(OFS_MODE3, md(2'(f), PAGE_ZERO));
                rd_burst(2'(f), f == 1 ? 2'b00 : 2'b01, 14'h0, x[0], 0, 1'b0);
            end
        end
        fork
            for (int k = 0; k < 4; k++) ctl.op(k % 2 ? CMD_RDA : CMD_RD, 2'(k), 14'h0, 8);
            collect(FMT_STAGGER, 2'b00, 32, 1'b1, 0, 1'b0);
        join
    endtask : t_reads
    // Chopped bursts, on-the-fly length, parity delay
    task automatic t_burst;
        wr(OFS_BURST, 32'(BL_FIXED4));
        for (int a2 = 0; a2 < 2; a2++) rd_burst(FMT_STAGGER, 2'b10, 14'(a2 * 4), 1'b1, a2 * 4, 1'b1);
        wr(OFS_BURST, 32'(BL_OTF));
        rd_burst(FMT_STAGGER, 2'b11, 14'h1000, 1'b1, 0, 1'b0);
        wr(OFS_LAT, lat(1, 2, 2, 1'b1, 1'b1));
        rd_burst(FMT_STAGGER, 2'b01, 14'h1000, 1'b1, 0, 1'b0);
    endtask : t_burst
    // Refused commands flag status; write-one clears
    task automatic t_status;
        ctl.op(CMD_REF, 2'b00, 14'h0, 4);
        ctl.op(CMD_REF_FGR, 2'b00, 14'h0, 4);
        wr(OFS_MODE3, md(FMT_RSVD, PAGE_ZERO));
        ctl.op(CMD_RD, 2'b00, 14'h1000, 20);
        wr(OFS_MODE3, md(FMT_SERIAL, 2'b01));
        ctl.op(CMD_WR, 2'b00, 14'h00FF, 4);
        rchk(OFS_STS, (32'h1 << STS_FGR) | (32'h1 << STS_FMT) | (32'h1 << STS_PAGE), 1'b0);
        rchk(OFS_PAT, {pat[3], pat[2], pat[1], pat[0]}, 1'b0);
        wr(OFS_STS, 32'h0000_001F);
        rchk(OFS_STS, 32'h0, 1'b0);
        wr(OFS_MODE3, 32'h0);
        rchk(OFS_MODE3, 32'h0, 1'b0);
    endtask : t_status
    // Reset for five cycles, then the scenarios
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_reset_map();
        t_write();
        t_reads();
        t_burst();
        t_status();
        give_verdict();
    end
endmodule : tb_dram_pattern_register_access
`default_nettype wire
